// ==== design/apc_protection_ctrl.v ====
// fault latch, recovery sequencer, strap decode and ahb-lite registers
`timescale 1ns/1ps
`include "apc_map.vh"
`default_nettype none
module apc_protection_ctrl #(
   parameter CNT_W = 10
) (
   input wire core_clk_in,
   input wire reset_in,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hsel,
   input wire hready,
   input wire [31:0] hwdata,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire amp_reset_n_in,
   input wire pwm_in,
   input wire protection_select_a_in,
   input wire protection_select_b_in,
   input wire output_config_select_in,
   input wire thermal_warning_flag_in,
   input wire thermal_fault_sense_in,
   input wire supply_low_lockout_in,
   input wire current_limit_trip_in,
   output reg bridge_enable_out,
   output reg bridge_tied_output_out,
   output wire thermal_warning_n_out,
   output wire thermal_warning_n_oe_out,
   output wire fault_flag_n_out,
   output wire fault_flag_n_oe_out
);
   // ***********************************
   // strap capture and mode decode
   // ***********************************
   reg strap_taken_reg;
   reg [1:0] prot_mode_reg;
   reg bridge_cfg_ok_reg;
   reg test_enable_reg;
   wire [1:0] eff_mode;
   // straps sampled once after reset release, never under the reset itself
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         strap_taken_reg <= 1'b0;
         prot_mode_reg <= `APC_MODE_RSVD;
         bridge_cfg_ok_reg <= 1'b0;
         bridge_tied_output_out <= 1'b0;
      end else if (!strap_taken_reg) begin
         strap_taken_reg <= 1'b1;
         if (protection_select_a_in)
            prot_mode_reg <= `APC_MODE_RSVD;
         else if (protection_select_b_in)
            prot_mode_reg <= `APC_MODE_LATCH;
         else
            prot_mode_reg <= `APC_MODE_SELF;
         bridge_cfg_ok_reg <= ~output_config_select_in;
         bridge_tied_output_out <= ~output_config_select_in;
      end
   end
   // test mode only through the dedicated control bit
   assign eff_mode = test_enable_reg ? `APC_MODE_TEST : prot_mode_reg;
   wire prot_on;
   assign prot_on = (eff_mode != `APC_MODE_TEST);
   // reserved output config keeps the bridge parked; reserved protection straps do so only while the test bit is clear
   wire cfg_valid;
   assign cfg_valid = strap_taken_reg && bridge_cfg_ok_reg && (eff_mode != `APC_MODE_RSVD);
   // ***********************************
   // fault conditions
   // ***********************************
   // single shared sense per fault type covers both half-bridges
   wire any_fault;
   assign any_fault = prot_on & (thermal_fault_sense_in | supply_low_lockout_in
      | current_limit_trip_in);
   // ***********************************
   // protection latch and sequencer
   // ***********************************
   reg latch_reg;
   reg hiz_reg;
   reg ote_reg;
   reg rst_prev_reg;
   reg latch_next;
   reg hiz_next;
   reg ote_next;
   wire rst_fall;
   wire rst_rise;
   wire rec_half;
   wire rec_full;
   wire rec_running;
   wire [CNT_W-1:0] rec_count;
   wire rec_start;
   assign rst_fall = rst_prev_reg & ~amp_reset_n_in;
   assign rst_rise = ~rst_prev_reg & amp_reset_n_in;
   assign rec_start = (eff_mode == `APC_MODE_SELF) && any_fault && !latch_reg;
   apc_recover_counter #(
      .CNT_W(CNT_W),
      .RECOVER_N(`APC_RECOVER_CYCLES)
   ) u_recover (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .start_in(rec_start),
      .abort_in(~amp_reset_n_in | (eff_mode != `APC_MODE_SELF)),
      .pwm_in(pwm_in),
      .half_out(rec_half),
      .full_out(rec_full),
      .running_out(rec_running),
      .count_out(rec_count)
   );
   // next state of the error latch, the hi-z hold and the thermal cause
   always @* begin
      latch_next = latch_reg;
      hiz_next = hiz_reg;
      ote_next = ote_reg;
      if (!amp_reset_n_in) begin
         hiz_next = 1'b1;
         if (rst_fall || !latch_reg) begin
            // falling edge wipes the error, unless one is still present
            latch_next = any_fault;
            ote_next = any_fault & thermal_fault_sense_in;
         end
      end else if (any_fault) begin
         // set wins over any clear in the same cycle
         latch_next = 1'b1;
         ote_next = ote_reg | thermal_fault_sense_in;
         hiz_next = 1'b1;
      end else if (rec_half) begin
         latch_next = 1'b0;
         ote_next = 1'b0;
      end else if (rec_full && !latch_reg) begin
         // a latch set again after the half point blocks this resume
         hiz_next = !cfg_valid;
      end else if (rst_rise && !latch_reg) begin
         hiz_next = !cfg_valid;
      end
   end
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         latch_reg <= 1'b0;
         hiz_reg <= 1'b1;
         ote_reg <= 1'b0;
         rst_prev_reg <= 1'b0;
      end else begin
         rst_prev_reg <= amp_reset_n_in;
         latch_reg <= latch_next;
         hiz_reg <= hiz_next;
         ote_reg <= ote_next;
      end
   end
   always @(posedge core_clk_in) begin
      if (reset_in)
         bridge_enable_out <= 1'b0;
      else
         bridge_enable_out <= !hiz_reg && amp_reset_n_in && !any_fault && cfg_valid;
   end
   // ***********************************
   // open-drain status pins
   // ***********************************
   wire fault_pull;
   wire warn_pull;
   // reset low releases the fault pin whatever the latch holds
   assign fault_pull = amp_reset_n_in & latch_reg;
   assign warn_pull = (prot_on & thermal_warning_flag_in) | (amp_reset_n_in & ote_reg);
   assign fault_flag_n_out = 1'b0;
   assign fault_flag_n_oe_out = fault_pull;
   assign thermal_warning_n_out = 1'b0;
   assign thermal_warning_n_oe_out = warn_pull;
   // ***********************************
   // ahb-lite slave
   // ***********************************
   reg dp_valid_reg;
   reg dp_write_reg;
   reg [7:0] dp_addr_reg;
   wire ap_take;
   assign ap_take = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         dp_valid_reg <= 1'b0;
         dp_write_reg <= 1'b0;
         dp_addr_reg <= 8'h00;
      end else if (hready) begin
         dp_valid_reg <= ap_take;
         dp_write_reg <= hwrite;
         dp_addr_reg <= haddr[7:0];
      end
   end
   localparam [31:0] CTRL_RST = `APC_CTRL_RESET;
   always @(posedge core_clk_in) begin
      if (reset_in)
         test_enable_reg <= CTRL_RST[`APC_CTRL_TEST_BIT];
      else if (dp_valid_reg && dp_write_reg && dp_addr_reg == `APC_CTRL_OFS)
         test_enable_reg <= hwdata[`APC_CTRL_TEST_BIT];
   end
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h0000_0000;
      case (haddr[7:0])
         `APC_CTRL_OFS: rd_mux[`APC_CTRL_TEST_BIT] = test_enable_reg;
         `APC_STATUS_OFS: begin
            rd_mux[`APC_ST_LATCH_BIT] = latch_reg;
            rd_mux[`APC_ST_HIZ_BIT] = hiz_reg;
            rd_mux[`APC_ST_WARN_BIT] = thermal_warning_flag_in;
            rd_mux[`APC_ST_OTE_BIT] = ote_reg;
            rd_mux[`APC_ST_UVP_BIT] = supply_low_lockout_in;
            rd_mux[`APC_ST_OC_BIT] = current_limit_trip_in;
            rd_mux[`APC_ST_RECOV_BIT] = rec_running;
            rd_mux[`APC_ST_RSVD_BIT] = !cfg_valid;
         end
         `APC_STRAP_OFS: rd_mux[3:0] = {bridge_tied_output_out, eff_mode, strap_taken_reg};
         `APC_COUNT_OFS: rd_mux[CNT_W-1:0] = rec_count;
         default: rd_mux = 32'h0000_0000;
      endcase
   end
   always @(posedge core_clk_in) begin
      if (reset_in)
         hrdata <= 32'h0000_0000;
      else if (ap_take && !hwrite)
         hrdata <= rd_mux;
   end
endmodule
`default_nettype wire

// ==== design/apc_recover_counter.v ====
// self-recovery counter advanced once per pwm input cycle
`timescale 1ns/1ps
`include "apc_map.vh"
`default_nettype none
module apc_recover_counter #(
   parameter CNT_W = 10,
   parameter [CNT_W-1:0] RECOVER_N = `APC_RECOVER_CYCLES
) (
   input wire core_clk_in,
   input wire reset_in,
   input wire start_in,
   input wire abort_in,
   input wire pwm_in,
   output reg half_out,
   output reg full_out,
   output reg running_out,
   output reg [CNT_W-1:0] count_out
);
   reg pwm_prev_reg;
   wire pwm_rise;
   assign pwm_rise = pwm_in & ~pwm_prev_reg;
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         pwm_prev_reg <= 1'b0;
         running_out <= 1'b0;
         count_out <= {CNT_W{1'b0}};
         half_out <= 1'b0;
         full_out <= 1'b0;
      end else begin
         pwm_prev_reg <= pwm_in;
         half_out <= 1'b0;
         full_out <= 1'b0;
         if (abort_in) begin
            running_out <= 1'b0;
            count_out <= {CNT_W{1'b0}};
         end else if (start_in) begin
            // a fresh error restarts from zero, even mid-count, unless abort_in is high in the same cycle
            running_out <= 1'b1;
            count_out <= {CNT_W{1'b0}};
         end else if (running_out && pwm_rise) begin
            // one step per pwm period, so delay scales with switching rate
            count_out <= count_out + 1'b1;
            if (count_out + 1'b1 == (RECOVER_N >> 1))
               half_out <= 1'b1;
            if (count_out + 1'b1 == RECOVER_N) begin
               full_out <= 1'b1;
               running_out <= 1'b0;
               count_out <= {CNT_W{1'b0}};
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== include/apc_map.vh ====
// constants of the amplifier protection controller
`ifndef APC_MAP_VH
`define APC_MAP_VH
// ***********************************
// register offsets (byte addresses)
// ***********************************
`define APC_CTRL_OFS 8'h00
`define APC_STATUS_OFS 8'h04
`define APC_STRAP_OFS 8'h08
`define APC_COUNT_OFS 8'h0C
// ***********************************
// control register fields
// ***********************************
`define APC_CTRL_TEST_BIT 0
`define APC_CTRL_RESET 32'h0000_0000
// ***********************************
// status register fields
// ***********************************
`define APC_ST_LATCH_BIT 0
`define APC_ST_HIZ_BIT 1
`define APC_ST_WARN_BIT 2
`define APC_ST_OTE_BIT 3
`define APC_ST_UVP_BIT 4
`define APC_ST_OC_BIT 5
`define APC_ST_RECOV_BIT 6
`define APC_ST_RSVD_BIT 7
// ***********************************
// protection mode encodings
// ***********************************
`define APC_MODE_SELF 2'h0
`define APC_MODE_LATCH 2'h1
`define APC_MODE_TEST 2'h2
`define APC_MODE_RSVD 2'h3
// ***********************************
// timing counts
// ***********************************
`define APC_RECOVER_CYCLES 10'h200
`endif

// ==== test/apc_ctl_model.sv ====
// pwm modulator and reset controller in front of the power stage
`timescale 1ns/1ps
`default_nettype none
module apc_ctl_model (
   input wire logic core_clk_in,
   input wire logic mute_in,
   output logic pwm_out,
   output logic amp_reset_n_out
);
   logic [2:0] div_reg = 3'h0;
   logic [4:0] warm_reg = 5'h0;
   initial pwm_out = 1'b0;
   initial amp_reset_n_out = 1'b0;
   // pwm never stops, so reset always falls before pwm is lost
   always @(posedge core_clk_in) begin
      div_reg <= div_reg + 3'h1;
      pwm_out <= div_reg[2];
      if (div_reg == 3'h3 && !warm_reg[4]) begin
         warm_reg <= warm_reg + 5'h1;
      end
      amp_reset_n_out <= !mute_in && warm_reg[4];
   end
endmodule
`default_nettype wire

// ==== test/apc_protection_ctrl_sva.sv ====
// checker for the protection controller pins and bus
`timescale 1ns/1ps
`default_nettype none
module apc_prot_sva (
   input wire core_clk_in,
   input wire reset_in,
   input wire amp_reset_n_in,
   input wire thermal_warning_flag_in,
   input wire hreadyout,
   input wire hresp,
   input wire bridge_enable_out,
   input wire thermal_warning_n_out,
   input wire thermal_warning_n_oe_out,
   input wire fault_flag_n_out,
   input wire fault_flag_n_oe_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   ready_high_a: assert property (hreadyout && !hresp) else $error("bus not ready or okay");
   od_level_a: assert property (!fault_flag_n_out && !thermal_warning_n_out)
      else $error("open-drain data not low");
   warn_cause_a: assert property (thermal_warning_n_oe_out |->
      (thermal_warning_flag_in || fault_flag_n_oe_out))
      else $error("warning without flag");
   fault_mute_a: assert property (!amp_reset_n_in |-> !fault_flag_n_oe_out)
      else $error("fault pin low in reset");
   rst_hiz_a: assert property (!amp_reset_n_in [*3] |-> !bridge_enable_out)
      else $error("switching in reset");
   fault_hiz_a: assert property (fault_flag_n_oe_out |-> ##[0:1] !bridge_enable_out)
      else $error("switching while faulted");
   resume_rst_a: assert property ($rose(bridge_enable_out) |-> $past(amp_reset_n_in))
      else $error("resume while reset low");
   resume_ok_a: assert property ($rose(bridge_enable_out) |-> !fault_flag_n_oe_out)
      else $error("resume with latched fault");
endmodule
bind apc_protection_ctrl apc_prot_sva i_sva (.core_clk_in(core_clk_in), .reset_in(reset_in),
   .amp_reset_n_in(amp_reset_n_in), .thermal_warning_flag_in(thermal_warning_flag_in),
   .hreadyout(hreadyout), .hresp(hresp), .bridge_enable_out(bridge_enable_out),
   .thermal_warning_n_out(thermal_warning_n_out),
   .thermal_warning_n_oe_out(thermal_warning_n_oe_out),
   .fault_flag_n_out(fault_flag_n_out), .fault_flag_n_oe_out(fault_flag_n_oe_out));
`default_nettype wire

// ==== test/test_amp_protection_controller.sv ====
// self-checking bench for the amplifier protection controller
`timescale 1ns/1ps
`default_nettype none
`include "apc_map.vh"
module test_amp_protection_controller;
   logic core_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic sel_a = 1'b0;
   logic sel_b = 1'b1;
   logic cfg = 1'b0;
   logic warn = 1'b0;
   logic [2:0] flt = 3'h0;
   logic mute = 1'b1;
   logic [31:0] rd;
   wire [31:0] hrdata;
   wire hreadyout, hresp, pwm, amp_rst_n, bridge_en, bridge_tied_output, warn_o, warn_oe, fault_o, fault_oe;
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   always #12.5 core_clk_in = ~core_clk_in;
   apc_ctl_model i_ctl (.core_clk_in(core_clk_in), .mute_in(mute), .pwm_out(pwm),
      .amp_reset_n_out(amp_rst_n));
   apc_protection_ctrl i_dut (.core_clk_in(core_clk_in), .reset_in(reset_in), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hsel(hsel), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .amp_reset_n_in(amp_rst_n), .pwm_in(pwm), .protection_select_a_in(sel_a),
      .protection_select_b_in(sel_b), .output_config_select_in(cfg),
      .thermal_warning_flag_in(warn), .thermal_fault_sense_in(flt[2]),
      .supply_low_lockout_in(flt[1]), .current_limit_trip_in(flt[0]),
      .bridge_enable_out(bridge_en), .bridge_tied_output_out(bridge_tied_output),
      .thermal_warning_n_out(warn_o), .thermal_warning_n_oe_out(warn_oe),
      .fault_flag_n_out(fault_o), .fault_flag_n_oe_out(fault_oe));
   // ***********************************
   // helpers
   // ***********************************
   task cyc(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask
   task pw(input int n);
      repeat (n) @(posedge pwm);
      @(posedge core_clk_in);
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      hsel <= 1'b1;
      cyc(1);
      while (hreadyout !== 1'b1) cyc(1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      cyc(1);
      while (hreadyout !== 1'b1) cyc(1);
      rd = hrdata;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // expected {bridge_en, warn_oe, fault_oe}
   task pins(input logic [2:0] e);
      chk({29'h0, bridge_en, warn_oe, fault_oe}, {29'h0, e});
   endtask
   task hard_reset(input logic a, input logic b, input logic c);
      mute <= 1'b1;
      sel_a <= a;
      sel_b <= b;
      cfg <= c;
      reset_in <= 1'b1;
      cyc(3);
      reset_in <= 1'b0;
      cyc(2);
   endtask
   task toggle;
      mute <= 1'b1;
      cyc(3);
      mute <= 1'b0;
      pw(4);
   endtask
   // ***********************************
   // scenarios
   // ***********************************
   task s_regs;
      bus(1'b0, `APC_CTRL_OFS, 32'h0);
      chk(rd, `APC_CTRL_RESET);
      bus(1'b1, `APC_CTRL_OFS, 32'h1);
      bus(1'b0, `APC_CTRL_OFS, 32'h0);
      chk(rd, 32'h1);
      bus(1'b1, `APC_CTRL_OFS, 32'h0);
      bus(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, `APC_STRAP_OFS, 32'h0);
      chk(rd, 32'hB);
   endtask
   task s_latch;
      mute <= 1'b0;
      pw(20);
      pins(3'b100);
      warn <= 1'b1;
      cyc(3);
      pins(3'b110);
      flt <= 3'b100;
      cyc(3);
      pins(3'b011);
      flt <= 3'h0;
      warn <= 1'b0;
      pw(600);
      pins(3'b011);
      bus(1'b0, `APC_STATUS_OFS, 32'h0);
      chk(rd & 32'hFF, 32'h0B);
      for (int i = 0; i < 2; i++) begin
         mute <= 1'b1;
         cyc(3);
         pins(3'b000);
         mute <= 1'b0;
         pw(4);
         pins(3'b100);
         flt <= 3'h1 << i;
         cyc(3);
         pins(3'b001);
         flt <= 3'h0;
      end
      toggle();
   endtask
   task s_test;
      bus(1'b1, `APC_CTRL_OFS, 32'h1);
      flt <= 3'b010;
      cyc(3);
      pins(3'b100);
      flt <= 3'h0;
      bus(1'b1, `APC_CTRL_OFS, 32'h0);
   endtask
   task s_self;
      hard_reset(1'b0, 1'b0, 1'b0);
      mute <= 1'b0;
      pw(20);
      flt <= 3'b010;
      cyc(2);
      flt <= 3'h0;
      pw(200);
      bus(1'b0, `APC_STATUS_OFS, 32'h0);
      chk(rd & 32'h3, 32'h3);
      pw(100);
      bus(1'b0, `APC_STATUS_OFS, 32'h0);
      chk(rd & 32'h3, 32'h2);
      pw(200);
      pins(3'b000);
      pw(30);
      pins(3'b100);
      flt <= 3'b010;
      pw(600);
      pins(3'b001);
      flt <= 3'h0;
      toggle();
   endtask
   task s_rsvd;
      hard_reset(1'b1, 1'b0, 1'b0);
      mute <= 1'b0;
      pw(20);
      pins(3'b000);
      hard_reset(1'b0, 1'b0, 1'b1);
      mute <= 1'b0;
      pw(20);
      chk({31'h0, bridge_tied_output}, 32'h0);
      pins(3'b000);
   endtask
   task close_out;
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 40000) begin
         bad_count++;
         close_out();
      end
   end
   initial begin
      cyc(3);
      reset_in <= 1'b0;
      cyc(2);
      s_regs();
      s_latch();
      s_test();
      s_self();
      s_rsvd();
      close_out();
   end
endmodule
`default_nettype wire
